// *** logic/spsc_pkg.sv ***
// Purpose: shared constants for the self-program section controller
// Assumes: APB register window, 32-bit data, byte addresses
// Notes:   offsets, bit positions and reset values live here only

package spsc_pkg;

	// ---------------------------------------------------------------
	// geometry defaults
	// ---------------------------------------------------------------
	localparam int FLASH_AW        = 15;  // word address width
	localparam int BOOT_MIN_WORDS  = 256; // smallest boot section

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
	localparam logic [11:0] OFS_LOCK        = 12'h004;
	localparam logic [11:0] OFS_INT_STATUS  = 12'h008;
	localparam logic [11:0] OFS_INT_MASK    = 12'h00C;
	localparam logic [11:0] OFS_BOOT_INFO   = 12'h010;

	// ---------------------------------------------------------------
	// store_program_control_status fields
	// ---------------------------------------------------------------
	localparam int CS_ARM_BIT    = 0; // rw: arm next store program
	localparam int CS_CLEAR_BIT  = 1; // w1: release read block
	localparam int CS_BUSY_BIT   = 4; // ro: rww_area_busy_flag
	localparam int CS_ACTIVE_BIT = 5; // ro: page operation running
	localparam int CS_HALT_BIT   = 6; // ro: cpu halted

	// ---------------------------------------------------------------
	// lock register fields (1 = unprogrammed, write can only clear)
	// ---------------------------------------------------------------
	localparam int LOCK_W          = 4;
	localparam int LOCK_APP_WR_BIT = 0;
	localparam int LOCK_APP_RD_BIT = 1;
	localparam int LOCK_BOOT_WR_BIT = 2;
	localparam int LOCK_BOOT_RD_BIT = 3;
	localparam logic [LOCK_W-1:0] LOCK_RESET = 4'hF;

	// ---------------------------------------------------------------
	// interrupt status / mask fields
	// ---------------------------------------------------------------
	localparam int INT_W        = 3;
	localparam int INT_DONE_BIT = 0; // page operation finished
	localparam int INT_IGN_BIT  = 1; // store program ignored
	localparam int INT_LOCK_BIT = 2; // refused by lock bits
	localparam logic [INT_W-1:0] INT_RESET  = 3'h0;
	localparam logic [INT_W-1:0] MASK_RESET = 3'h0;

	// ---------------------------------------------------------------
	// misc reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  FUSE_RESET  = 2'h3;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// sequencer states
	typedef enum logic [0:0] {
		SPSC_IDLE,
		SPSC_PROG
	} spsc_state_e;

endpackage

// *** logic/spsc_sec_if.sv ***
// Purpose: carries one address and its section classification
// Assumes: one decoder drives the outputs, the controller reads them
// Notes:   boot size comes from the synchronised fuse value

`timescale 1ns/10ps

interface spsc_sec_if #(
	parameter int AW = 15
);
	logic [AW-1:0] addr;
	logic [1:0]    boot_size_fuses;
	logic          in_boot;
	logic          in_rww;

	modport dec (
		input  addr,
		input  boot_size_fuses,
		output in_boot,
		output in_rww
	);

	modport user (
		output addr,
		output boot_size_fuses,
		input  in_boot,
		input  in_rww
	);
endinterface

// *** logic/spsc_section_decode.sv ***
// Purpose: classify a flash word address into boot/application and
//          read_while_write_area/no_read_while_write_area
// Assumes: boot section and no-read-while-write area sit at the top
// Notes:   the fixed area equals the largest boot size

`timescale 1ns/10ps

module spsc_section_decode #(
	parameter int AW   = 15,
	parameter int BMIN = 256
) (
	// classified address
	spsc_sec_if.dec s
);

	logic [AW:0] top_addr;
	logic [AW:0] boot_words;
	logic [AW:0] boot_start;
	logic [AW:0] fixed_start;

	// fuse value 3 picks the smallest boot section, 0 the largest
	always_comb begin
		top_addr   = {1'b1, {AW{1'b0}}};
		boot_words = (AW+1)'(BMIN) << (2'h3 - s.boot_size_fuses);
		boot_start = top_addr - boot_words;
		// largest boot size fixes the area, so boot always lies inside
		fixed_start = top_addr - ((AW+1)'(BMIN) << 3);
		s.in_boot  = {1'b0, s.addr} >= boot_start;
		s.in_rww   = {1'b0, s.addr} < fixed_start;
	end

endmodule

// *** logic/spsc_self_program_ctrl.sv ***
// Purpose: gate store program requests by executing section, drive the
//          flash page operation and hold or release cpu fetching
// Assumes: cpu and flash array run on pclk; boot fuses are a pin
// Notes:   apb slave with zero wait states, pslverr on unmapped words

`timescale 1ns/10ps

// What this block does
// - store program from application section is ignored, nothing starts.
// - erase or write starts only when issued from boot section.
// - accepted operation may target any page, boot pages included.
// - halt versus concurrent fetch follows the target address.
// - target in read-while-write area lets cpu keep fetching elsewhere.
// - target in no-read-while-write area halts cpu whole operation.
// - read-while-write area unreadable while its programming is active.
// - busy flag reads one while the area stays blocked.
// - after completion flag and block remain until software clears.
// - boot section always lies inside the fixed no-read-while-write area.
// - boot fuse setting sets application/boot boundary.
// - application lock bits alone protect the application section.
// - boot lock bits alone protect the boot section.
// - page grouping never affects fetching outside programming.
module spsc_self_program_ctrl #(
	parameter int AW   = spsc_pkg::FLASH_AW,
	parameter int BMIN = spsc_pkg::BOOT_MIN_WORDS
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic [11:0]   paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// cpu core
	input  wire logic          prog_req,
	input  wire logic          prog_erase,
	input  wire logic [AW-1:0] prog_pc,
	input  wire logic [AW-1:0] prog_target,
	input  wire logic [AW-1:0] fetch_addr,
	output logic               cpu_halt,
	output logic               rww_read_block,
	// flash array
	output logic               flash_start,
	output logic               flash_erase,
	output logic      [AW-1:0] flash_page,
	input  wire logic          flash_done,
	// fuse pins
	input  wire logic [1:0]    boot_size_fuses,
	// interrupt
	output logic               irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		spsc_pkg::spsc_state_e                state;
		logic                                 arm;
		logic                                 rww_busy;
		logic                                 tgt_rww;
		logic [AW-1:0]                        tgt;
		logic                                 erase;
		logic                                 start;
		logic [spsc_pkg::LOCK_W-1:0]          lock;
		logic [spsc_pkg::INT_W-1:0]           int_st;
		logic [spsc_pkg::INT_W-1:0]           int_mask;
		logic [1:0]                           fz1;
		logic [1:0]                           fz2;
		logic [31:0]                          rdata;
	} spsc_regs_s;

	spsc_regs_s r;
	spsc_regs_s next_r;

	// ---------------------------------------------------------------
	// section decoders
	// ---------------------------------------------------------------
	spsc_sec_if #(.AW(AW)) pc_sec ();
	spsc_sec_if #(.AW(AW)) tgt_sec ();
	spsc_sec_if #(.AW(AW)) fetch_sec ();

	// all three see the same synchronised fuse value
	assign pc_sec.addr               = prog_pc;
	assign pc_sec.boot_size_fuses    = r.fz2;
	assign tgt_sec.addr              = prog_target;
	assign tgt_sec.boot_size_fuses   = r.fz2;
	assign fetch_sec.addr            = fetch_addr;
	assign fetch_sec.boot_size_fuses = r.fz2;

	spsc_section_decode #(.AW(AW), .BMIN(BMIN)) u_pc_dec (
		.s (pc_sec)
	);

	spsc_section_decode #(.AW(AW), .BMIN(BMIN)) u_tgt_dec (
		.s (tgt_sec)
	);

	spsc_section_decode #(.AW(AW), .BMIN(BMIN)) u_fetch_dec (
		.s (fetch_sec)
	);

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        rd_setup;
	logic        addr_ok;
	logic        wr_cs;
	logic        wr_lock;
	logic        wr_ist;
	logic        wr_imask;

	// byte lane 0 carries every field, upper lanes are ignored
	assign acc      = psel & penable;
	assign wr       = acc & pwrite & pstrb[0];
	assign rd_setup = psel & ~penable & ~pwrite;
	assign addr_ok  = (paddr == spsc_pkg::OFS_CTRL_STATUS) |
	                  (paddr == spsc_pkg::OFS_LOCK) |
	                  (paddr == spsc_pkg::OFS_INT_STATUS) |
	                  (paddr == spsc_pkg::OFS_INT_MASK) |
	                  (paddr == spsc_pkg::OFS_BOOT_INFO);
	assign wr_cs    = wr & (paddr == spsc_pkg::OFS_CTRL_STATUS);
	assign wr_lock  = wr & (paddr == spsc_pkg::OFS_LOCK);
	assign wr_ist   = wr & (paddr == spsc_pkg::OFS_INT_STATUS);
	assign wr_imask = wr & (paddr == spsc_pkg::OFS_INT_MASK);

	// ---------------------------------------------------------------
	// request qualification
	// ---------------------------------------------------------------
	logic wr_inhibit;
	logic accept;
	logic ev_done;
	logic ev_ign;
	logic ev_lock;

	// each lock set covers only its own section
	always_comb begin
		if (tgt_sec.in_boot) begin
			wr_inhibit = ~r.lock[spsc_pkg::LOCK_BOOT_WR_BIT];
		end else begin
			wr_inhibit = ~r.lock[spsc_pkg::LOCK_APP_WR_BIT];
		end
	end

	// only boot resident code may start, any target page is allowed
	always_comb begin
		accept  = 1'b0;
		ev_ign  = 1'b0;
		ev_lock = 1'b0;
		if ((r.state == spsc_pkg::SPSC_IDLE) && prog_req) begin
			if (!r.arm || !pc_sec.in_boot) begin
				ev_ign = 1'b1;
			end else if (wr_inhibit) begin
				ev_lock = 1'b1;
			end else begin
				accept = 1'b1;
			end
		end
		ev_done = (r.state == spsc_pkg::SPSC_PROG) & flash_done;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic [spsc_pkg::INT_W-1:0] ev_vec;
	logic [spsc_pkg::INT_W-1:0] ist_clr;

	always_comb begin
		next_r       = r;
		next_r.start = 1'b0;
		// two flops on the fuse pins before any decoder reads them
		next_r.fz1   = boot_size_fuses;
		next_r.fz2   = r.fz1;

		// clear request is honoured only with the array idle
		if (wr_cs && pwdata[spsc_pkg::CS_CLEAR_BIT] &&
		    (r.state == spsc_pkg::SPSC_IDLE)) begin
			next_r.rww_busy = 1'b0;
		end
		if (wr_cs) begin
			next_r.arm = pwdata[spsc_pkg::CS_ARM_BIT];
		end

		case (r.state)
			spsc_pkg::SPSC_IDLE: begin
				if (accept) begin
					next_r.state   = spsc_pkg::SPSC_PROG;
					next_r.start   = 1'b1;
					next_r.tgt     = prog_target;
					next_r.erase   = prog_erase;
					// mode follows the page written, not the pc
					next_r.tgt_rww = tgt_sec.in_rww;
					if (tgt_sec.in_rww) begin
						// set after the clear above, so the set wins
						next_r.rww_busy = 1'b1;
					end
				end
			end
			spsc_pkg::SPSC_PROG: begin
				if (flash_done) begin
					next_r.state = spsc_pkg::SPSC_IDLE;
					next_r.arm   = 1'b0;
				end
			end
			default: begin
				next_r.state = spsc_pkg::SPSC_IDLE;
			end
		endcase

		// writes may only program lock bits, never release them; only presetn reloads them unprogrammed
		if (wr_lock) begin
			next_r.lock = r.lock & pwdata[spsc_pkg::LOCK_W-1:0];
		end

		// sticky events, write one to clear, a new event wins
		ev_vec = '0;
		ev_vec[spsc_pkg::INT_DONE_BIT] = ev_done;
		ev_vec[spsc_pkg::INT_IGN_BIT]  = ev_ign;
		ev_vec[spsc_pkg::INT_LOCK_BIT] = ev_lock;
		ist_clr = wr_ist ? pwdata[spsc_pkg::INT_W-1:0] : '0;
		next_r.int_st = (r.int_st & ~ist_clr) | ev_vec;
		if (wr_imask) begin
			next_r.int_mask = pwdata[spsc_pkg::INT_W-1:0];
		end

		// read data captured in setup so it is a flop in access
		if (rd_setup) begin
			next_r.rdata = '0;
			case (paddr)
				spsc_pkg::OFS_CTRL_STATUS: begin
					next_r.rdata[spsc_pkg::CS_ARM_BIT]    = r.arm;
					next_r.rdata[spsc_pkg::CS_BUSY_BIT]   = r.rww_busy;
					next_r.rdata[spsc_pkg::CS_ACTIVE_BIT] =
						(r.state == spsc_pkg::SPSC_PROG);
					next_r.rdata[spsc_pkg::CS_HALT_BIT]   = cpu_halt;
				end
				spsc_pkg::OFS_LOCK: begin
					next_r.rdata[spsc_pkg::LOCK_W-1:0] = r.lock;
				end
				spsc_pkg::OFS_INT_STATUS: begin
					next_r.rdata[spsc_pkg::INT_W-1:0] = r.int_st;
				end
				spsc_pkg::OFS_INT_MASK: begin
					next_r.rdata[spsc_pkg::INT_W-1:0] = r.int_mask;
				end
				spsc_pkg::OFS_BOOT_INFO: begin
					next_r.rdata[1:0] = r.fz2;
				end
				default: begin
					next_r.rdata = '0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.state    <= spsc_pkg::SPSC_IDLE;
			r.arm      <= 1'b0;
			r.rww_busy <= 1'b0;
			r.tgt_rww  <= 1'b0;
			r.tgt      <= '0;
			r.erase    <= 1'b0;
			r.start    <= 1'b0;
			r.lock     <= spsc_pkg::LOCK_RESET;
			r.int_st   <= spsc_pkg::INT_RESET;
			r.int_mask <= spsc_pkg::MASK_RESET;
			r.fz1      <= spsc_pkg::FUSE_RESET;
			r.fz2      <= spsc_pkg::FUSE_RESET;
			r.rdata    <= spsc_pkg::RDATA_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// halt covers the whole page operation on the fixed area
	assign cpu_halt = (r.state == spsc_pkg::SPSC_PROG) & ~r.tgt_rww;
	// only the busy flag blocks; pages play no part in plain fetching,
	// and fetches from the other area stay open meanwhile
	assign rww_read_block = r.rww_busy & fetch_sec.in_rww;

	assign flash_start = r.start;
	assign flash_erase = r.erase;
	assign flash_page  = r.tgt;

	assign prdata  = r.rdata;
	assign pready  = 1'b1;
	assign pslverr = acc & ~addr_ok;

	assign irq = |(r.int_st & r.int_mask);

endmodule

// *** testbench/spsc_ctrl_properties.sv ***
// Purpose: concurrent checks on the self-program controller ports
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes:   section bounds come from the AW and BMIN parameters

`timescale 1ns/10ps

module spsc_ctrl_properties #(
	parameter int AW   = 15,
	parameter int BMIN = 256
) (
	// clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// apb side
	input wire logic [11:0]   paddr,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [31:0]   pwdata,
	input wire logic [3:0]    pstrb,
	input wire logic          pready,
	input wire logic          pslverr,
	// cpu and flash side
	input wire logic          prog_req,
	input wire logic [AW-1:0] prog_pc,
	input wire logic [AW-1:0] fetch_addr,
	input wire logic          cpu_halt,
	input wire logic          rww_read_block,
	input wire logic          flash_start,
	input wire logic [AW-1:0] flash_page,
	input wire logic          flash_done
);
	// lowest word of the fixed area; boot never starts below it
	localparam logic [AW-1:0] FIXED_LO = AW'((1 << AW) - 8 * BMIN);
	logic clr_wr;

	// software clear of the busy flag completing on this edge
	assign clr_wr = psel && penable && pwrite && pstrb[0]
		&& paddr == spsc_pkg::OFS_CTRL_STATUS
		&& pwdata[spsc_pkg::CS_CLEAR_BIT];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// section gating and halt
	// ----------------------------------------------------------------
	a_app_pc_ignored: assert property (
		prog_req && prog_pc < FIXED_LO |=> !flash_start)
		else $error("store program from application started an op");
	a_start_pulse: assert property (flash_start |=> !flash_start)
		else $error("flash start longer than one cycle");
	a_halt_on_fixed: assert property (
		flash_start && flash_page >= FIXED_LO |-> cpu_halt)
		else $error("no halt for fixed area target");
	a_no_halt_rww: assert property (
		flash_start && flash_page < FIXED_LO |-> !cpu_halt)
		else $error("halt for read-while-write target");
	a_halt_holds: assert property (
		cpu_halt && !flash_done |=> cpu_halt)
		else $error("halt dropped before op end");
	a_halt_release: assert property (
		cpu_halt && flash_done |=> !cpu_halt)
		else $error("halt kept after op end");

	// ----------------------------------------------------------------
	// read block and bus
	// ----------------------------------------------------------------
	a_block_rww: assert property (
		flash_start && flash_page < FIXED_LO
		&& fetch_addr < FIXED_LO |-> rww_read_block)
		else $error("area readable while programmed");
	a_fixed_readable: assert property (
		fetch_addr >= FIXED_LO |-> !rww_read_block)
		else $error("fixed area fetch blocked");
	a_block_stays: assert property (
		rww_read_block && !clr_wr
		|=> rww_read_block || $changed(fetch_addr))
		else $error("read block released without clear");
	a_pready_high: assert property (pready)
		else $error("pready low");
	a_unmapped_err: assert property (
		psel && penable && paddr >= 12'h014 |-> pslverr)
		else $error("no error on unmapped offset");

	c_fixed_op: cover property (flash_start && cpu_halt);
	c_rww_op: cover property (flash_start && rww_read_block);
	c_halt_end: cover property (cpu_halt && flash_done);
endmodule

bind spsc_self_program_ctrl spsc_ctrl_properties #(.AW(AW), .BMIN(BMIN)) chk_u (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr), .prog_req(prog_req),
	.prog_pc(prog_pc), .fetch_addr(fetch_addr), .cpu_halt(cpu_halt),
	.rww_read_block(rww_read_block), .flash_start(flash_start),
	.flash_page(flash_page), .flash_done(flash_done)
);

// *** testbench/spsc_flash_model.sv ***
// Purpose: flash array stand-in answering page operations
// Assumes: same clock as the controller
// Notes:   op_cycles sets a prompt or slow array, minimum one

`timescale 1ns/10ps

module spsc_flash_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// page operation handshake
	input  wire logic        flash_start,
	input  wire logic [31:0] op_cycles,
	output logic             flash_done
);
	int cnt;

	// count down from each start, done is a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			flash_done <= 1'b0;
		end else begin
			flash_done <= (cnt == 1);
			if (flash_start)
				cnt <= op_cycles;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the self-program section controller
// Assumes: AW 10, BMIN 16, fixed area from word 0x380
// Notes:   rows cover section gating, hand tests the awkward cases

`timescale 1ns/10ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	err_total++; $display("CHECK FAILED t=%0t got %0h exp %0h", \
	$time, g, e); end end

module tb;
	typedef struct {
		logic [1:0] fuse;
		logic [9:0] pc;
		logic [9:0] tgt;
		logic       erase;
		logic       start;
		logic       halt;
	} spsc_row_s;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic        prog_req, prog_erase, cpu_halt, rww_read_block;
	logic [9:0]  prog_pc, prog_target, fetch_addr, flash_page;
	logic        flash_start, flash_erase, flash_done, irq, err;
	logic [1:0]  boot_size_fuses;
	int          op_cycles, err_total, checks_done;
	spsc_row_s   rows [7] = '{
		'{2'h3, 10'h3F2, 10'h010, 1'b1, 1'b1, 1'b0},
		'{2'h3, 10'h3F2, 10'h3F0, 1'b0, 1'b1, 1'b1},
		'{2'h3, 10'h3A0, 10'h010, 1'b1, 1'b0, 1'b0},
		'{2'h0, 10'h3A0, 10'h100, 1'b0, 1'b1, 1'b0},
		'{2'h0, 10'h37F, 10'h3FF, 1'b1, 1'b0, 1'b0},
		'{2'h1, 10'h3C0, 10'h380, 1'b1, 1'b1, 1'b1},
		'{2'h2, 10'h3DF, 10'h000, 1'b0, 1'b0, 1'b0}};

	spsc_self_program_ctrl #(.AW(10), .BMIN(16)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_req(prog_req),
		.prog_erase(prog_erase), .prog_pc(prog_pc),
		.prog_target(prog_target),
		.fetch_addr(fetch_addr), .cpu_halt(cpu_halt),
		.rww_read_block(rww_read_block), .flash_start(flash_start),
		.flash_erase(flash_erase), .flash_page(flash_page),
		.flash_done(flash_done), .boot_size_fuses(boot_size_fuses),
		.irq(irq));

	spsc_flash_model flash_u (.pclk(pclk), .presetn(presetn),
		.flash_start(flash_start), .op_cycles(op_cycles),
		.flash_done(flash_done));

	task automatic close_out();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one apb transfer, request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			err_total++;
			close_out();
		end
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e,
			input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask

	// arm, then issue one store program and look at the answer
	task automatic fire(input logic [9:0] pc, tgt, input logic er, st, h);
		apb(1'b1, spsc_pkg::OFS_CTRL_STATUS, 32'h1);
		@(posedge pclk);
		prog_req <= 1'b1;
		prog_pc <= pc;
		prog_target <= tgt;
		prog_erase <= er;
		@(posedge pclk);
		prog_req <= 1'b0;
		@(negedge pclk);
		`CHK(flash_start, st)
		`CHK(cpu_halt, h)
		if (st) begin
			`CHK(flash_page, tgt)
			`CHK(flash_erase, er)
			`CHK(rww_read_block, !h)
		end
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge pclk);
			if (flash_done === 1'b1)
				break;
		end
		if (i == 200) begin
			err_total++;
			close_out();
		end
		@(negedge pclk);
		`CHK(cpu_halt, 1'b0)
	endtask

	task automatic run_row(input spsc_row_s r);
		boot_size_fuses <= r.fuse;
		repeat (3) @(posedge pclk);
		fire(r.pc, r.tgt, r.erase, r.start, r.halt);
		if (r.start)
			wait_done();
		else
			repeat (2) @(posedge pclk);
		`CHK(rww_read_block, r.start && !r.halt)
		chk_rd(spsc_pkg::OFS_CTRL_STATUS, {27'h0, r.start && !r.halt, 4'h0},
			32'hFFFF_FFFE);
		apb(1'b1, spsc_pkg::OFS_CTRL_STATUS, 32'h2);
		chk_rd(spsc_pkg::OFS_CTRL_STATUS, 32'h0, 32'hFFFF_FFFF);
		chk_rd(spsc_pkg::OFS_BOOT_INFO, {30'h0, r.fuse},
			32'hFFFF_FFFF);
		chk_rd(spsc_pkg::OFS_INT_STATUS, r.start ? 32'h1 : 32'h2, 32'hF);
		apb(1'b1, spsc_pkg::OFS_INT_STATUS, 32'h7);
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, prog_req, prog_erase} = '0;
		{paddr, pwdata, prog_pc, prog_target, fetch_addr} = '0;
		{err_total, checks_done} = '0;
		pstrb = 4'hF;
		boot_size_fuses = 2'h3;
		op_cycles = 2;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk_rd(spsc_pkg::OFS_LOCK, 32'hF, 32'hFFFF_FFFF);
		chk_rd(12'h040, 32'h0, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		apb(1'b1, spsc_pkg::OFS_INT_MASK, 32'h1);
		foreach (rows[k])
			run_row(rows[k]);
		// slow rww op: a clear while it runs must be dropped
		op_cycles <= 30;
		fire(10'h3E4, 10'h020, 1'b0, 1'b1, 1'b0);
		apb(1'b1, spsc_pkg::OFS_CTRL_STATUS, 32'h2);
		fetch_addr <= 10'h390;
		@(negedge pclk);
		`CHK(rww_read_block, 1'b0)
		@(posedge pclk);
		fetch_addr <= 10'h000;
		wait_done();
		chk_rd(spsc_pkg::OFS_CTRL_STATUS, 32'h10, 32'hFFFF_FFFF);
		`CHK(irq, 1'b1)
		apb(1'b1, spsc_pkg::OFS_INT_MASK, 32'h0);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, spsc_pkg::OFS_INT_STATUS, 32'h7);
		apb(1'b1, spsc_pkg::OFS_CTRL_STATUS, 32'h2);
		// application write lock leaves boot pages writable
		apb(1'b1, spsc_pkg::OFS_LOCK, 32'hE);
		chk_rd(spsc_pkg::OFS_LOCK, 32'hE, 32'hFFFF_FFFF);
		fire(10'h3F0, 10'h010, 1'b1, 1'b0, 1'b0);
		chk_rd(spsc_pkg::OFS_INT_STATUS, 32'h4, 32'hF);
		apb(1'b1, spsc_pkg::OFS_INT_STATUS, 32'h7);
		// boot page target: allowed by boot lock, cpu halted
		fire(10'h3F0, 10'h3F8, 1'b1, 1'b1, 1'b1);
		// reset in mid operation
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK(cpu_halt, 1'b0)
		`CHK(flash_page, 10'h000)
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk_rd(spsc_pkg::OFS_LOCK, 32'hF, 32'hFFFF_FFFF);
		close_out();
	end
endmodule
